// *** common/scan_proc_defs.vh ***
// Constants for the scanner binarizing and colour correction stage.
// Assumes 8-bit brightness and 8-bit colour components on one pixel clock.
`ifndef SCAN_PROC_DEFS_VH
`define SCAN_PROC_DEFS_VH

`define MODE_SIMPLE     2'h0
`define MODE_DIFFUSE    2'h1
`define MODE_EDGE_TEXT  2'h2

`define PIX_WHITE       8'hFF
`define PIX_BLACK       8'h00
`define SLICE_MEDIAN    8'h80
`define ED_CODE_HI      4'hF
`define ED_CODE_LO      4'h0

`define BG_CNT_W        13
`define BG_STEP         8'h04
`define BG_SHIFT_MAX    8'h40

`define LUT_AW          9
`define LUT_DW          48
`define LUT_CELL_MSB    7
`define LUT_CELL_LSB    5
`define LUT_FRAC_W      5
`define LUT_CH_W        16

`define LINE_AW         13
`define DUAL_STEP       14'h0006

`endif

// *** hw/edge_window_filter.v ***
// Horizontal three-pixel window with two edge filters and an averaging
// threshold filter. Assumes the caller marks each line start; results for
// the centre pixel come out one pixel late, registered.
`timescale 1ns/1ps
`include "scan_proc_defs.vh"
module edge_window_filter (
	input  wire       clk_in,
	input  wire       rst_in,
	input  wire       valid_in,
	input  wire       line_start_in,
	input  wire [7:0] pix_in,
	input  wire [7:0] edge_level_in,
	output reg        valid_out,
	output reg        edge_out,
	output reg        dark_going_out,
	output reg  [7:0] thr_out,
	output reg  [7:0] centre_out
);
	reg  [7:0] left_ff;
	reg  [7:0] mid_ff;
	wire [7:0] left;
	wire [7:0] mid;
	wire [7:0] grad1;
	wire [7:0] grad2;
	wire [9:0] avg_sum;

	// Pixels before the line start count as white paper
	assign left    = line_start_in ? `PIX_WHITE : left_ff;
	assign mid     = line_start_in ? `PIX_WHITE : mid_ff;
	assign grad1   = (mid > left) ? mid - left : left - mid;
	assign grad2   = (pix_in > left) ? pix_in - left : left - pix_in;
	assign avg_sum = {2'b00, left} + {1'b0, mid, 1'b0} + {2'b00, pix_in};

	always @(posedge clk_in) begin
		if (rst_in) begin
			left_ff        <= `PIX_WHITE;
			mid_ff         <= `PIX_WHITE;
			valid_out      <= 1'b0;
			edge_out       <= 1'b0;
			dark_going_out <= 1'b0;
			thr_out        <= `SLICE_MEDIAN;
			centre_out     <= `PIX_WHITE;
		end else begin
			valid_out <= valid_in;
			if (valid_in) begin
				left_ff        <= mid;
				mid_ff         <= pix_in;
				edge_out       <= (grad1 > edge_level_in) ||
				                  (grad2 > edge_level_in);
				dark_going_out <= pix_in < left;
				thr_out        <= avg_sum[9:2];
				centre_out     <= mid;
			end
		end
	end
endmodule

// *** hw/scan_binarize_color_correct.v ***
// Pixel stage: slice binarizing with background tracking, error diffusion,
// edge based text binarizing, 3-D colour correction with custom dropout,
// and replay of a stored line as a second low-resolution binary output.
// Assumes one pixel per PIX_VALID_IN, LINE_END_IN on the last pixel, and an
// upstream that holds off while DUAL_BUSY_OUT is high.
`timescale 1ns/1ps
`include "scan_proc_defs.vh"

module scan_binarize_color_correct (
	input  wire        REF_CLK_IN,
	input  wire        RST_IN,
	input  wire        PIX_VALID_IN,
	input  wire        LINE_START_IN,
	input  wire        LINE_END_IN,
	input  wire [7:0]  GRAY_IN,
	input  wire        COLOR_DATA_IN,
	input  wire [7:0]  RED_IN,
	input  wire [7:0]  GREEN_IN,
	input  wire [7:0]  BLUE_IN,
	input  wire [1:0]  MODE_IN,
	input  wire [7:0]  SLICE_LEVEL_IN,
	input  wire [7:0]  ED_BRIGHT_IN,
	input  wire        BG_TRACK_EN_IN,
	input  wire [7:0]  BG_BRIGHT_IN,
	input  wire [12:0] BG_LIMIT_IN,
	input  wire [7:0]  EDGE_LEVEL_IN,
	input  wire        DROPOUT_EN_IN,
	input  wire [23:0] DROP_LO_IN,
	input  wire [23:0] DROP_HI_IN,
	input  wire        LUT_WE_IN,
	input  wire [8:0]  LUT_ADDR_IN,
	input  wire [47:0] LUT_DATA_IN,
	input  wire        DUAL_EN_IN,
	output reg         BIN_VALID_OUT,
	output reg         BIN_OUT,
	output reg  [3:0]  ED_OUT,
	output reg         COLOR_VALID_OUT,
	output reg  [7:0]  RED_OUT,
	output reg  [7:0]  GREEN_OUT,
	output reg  [7:0]  BLUE_OUT,
	output reg  [2:0]  LAMP_ALL_ON_OUT,
	output reg         DUAL_BUSY_OUT,
	output reg         DUAL_VALID_OUT,
	output reg         DUAL_BIN_OUT
);
	localparam ST_IDLE   = 1'b0;
	localparam ST_REPLAY = 1'b1;

	// Background tracking
	reg  [`BG_CNT_W-1:0] bg_cnt_ff;
	reg  [7:0]           bg_shift_ff;
	reg  [7:0]           nxt_bg_shift;
	wire [7:0]           slice_eff;
	wire                 bright_pix;
	// Error diffusion
	reg  signed [10:0] err_ff;
	wire signed [10:0] err_in;
	wire signed [10:0] ed_adj;
	wire        [7:0]  ed_conv;
	wire signed [10:0] ed_corr;
	wire               ed_white;
	wire signed [10:0] ed_emit;
	// Edge text path
	wire       e_valid;
	wire       e_edge;
	wire       e_dark;
	wire [7:0] e_thr;
	wire [7:0] e_centre;
	reg  [7:0] thr_mean_ff;
	reg        inside_ff;
	reg        edge_bin;
	wire [8:0] mean_sum;
	// Colour path
	reg         col_valid_ff;
	reg         col_bypass_ff;
	reg         col_drop_ff;
	reg  [23:0] col_rgb_ff;
	wire [23:0] rgb_in;
	wire [47:0] lut_rdata;
	wire [23:0] corr_rgb;
	wire        in_range;
	// Dual output
	reg                  dual_st_ff;
	reg  [`LINE_AW-1:0]  wcnt_ff;
	reg  [`LINE_AW:0]    len_ff;
	reg  [`LINE_AW:0]    raddr_ff;
	reg                  rd_pend_ff;
	wire [7:0]           line_rdata;
	wire                 line_we;
	assign rgb_in   = {RED_IN, GREEN_IN, BLUE_IN};
	assign in_range = (RED_IN >= DROP_LO_IN[23:16]) &&
	                  (RED_IN <= DROP_HI_IN[23:16]) &&
	                  (GREEN_IN >= DROP_LO_IN[15:8]) &&
	                  (GREEN_IN <= DROP_HI_IN[15:8]) &&
	                  (BLUE_IN >= DROP_LO_IN[7:0]) &&
	                  (BLUE_IN <= DROP_HI_IN[7:0]);
	// Background level: judged at each line start on the line just ended
	assign bright_pix = GRAY_IN >= BG_BRIGHT_IN;
	always @* begin
		nxt_bg_shift = bg_shift_ff;
		if (LINE_START_IN && PIX_VALID_IN && BG_TRACK_EN_IN) begin
			if (bg_cnt_ff > BG_LIMIT_IN) begin
				if (bg_shift_ff < `BG_SHIFT_MAX)
					nxt_bg_shift = bg_shift_ff + `BG_STEP;
			end else if (bg_shift_ff != 8'h00) begin
				nxt_bg_shift = bg_shift_ff - `BG_STEP;
			end
		end else if (!BG_TRACK_EN_IN) begin
			nxt_bg_shift = 8'h00;
		end
	end
	// Lower slice lets a tinted background come out white
	assign slice_eff = (SLICE_LEVEL_IN > nxt_bg_shift) ?
	                   SLICE_LEVEL_IN - nxt_bg_shift : 8'h00;
	// Diffusion: brightness offset stands in for the conversion table
	assign err_in  = LINE_START_IN ? 11'sd0 : err_ff;
	assign ed_adj  = $signed({3'b000, GRAY_IN}) +
	                 $signed({{3{ED_BRIGHT_IN[7]}}, ED_BRIGHT_IN});
	assign ed_conv = ed_adj[10] ? 8'h00 :
	                 (ed_adj[9:8] != 2'b00) ? 8'hFF : ed_adj[7:0];
	assign ed_corr = $signed({3'b000, ed_conv}) + err_in;
	assign ed_white = ed_corr >= $signed({3'b000, `SLICE_MEDIAN});
	assign ed_emit = ed_white ? $signed({3'b000, `PIX_WHITE}) : 11'sd0;

	edge_window_filter u_edge (
		.clk_in         (REF_CLK_IN),
		.rst_in         (RST_IN),
		.valid_in       (PIX_VALID_IN),
		.line_start_in  (LINE_START_IN),
		.pix_in         (GRAY_IN),
		.edge_level_in  (EDGE_LEVEL_IN),
		.valid_out      (e_valid),
		.edge_out       (e_edge),
		.dark_going_out (e_dark),
		.thr_out        (e_thr),
		.centre_out     (e_centre)
	);

	// Running mean keeps one adder instead of a divider
	assign mean_sum = {1'b0, thr_mean_ff} + {1'b0, e_thr};
	always @* begin
		if (e_edge) begin
			edge_bin = e_centre >= e_thr;
		end else if (inside_ff) begin
			edge_bin = e_centre >= thr_mean_ff;
		end else begin
			edge_bin = 1'b1;
		end
	end

	always @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			bg_cnt_ff     <= {`BG_CNT_W{1'b0}};
			bg_shift_ff   <= 8'h00;
			err_ff        <= 11'sd0;
			thr_mean_ff   <= `SLICE_MEDIAN;
			inside_ff     <= 1'b0;
			BIN_VALID_OUT <= 1'b0;
			BIN_OUT       <= 1'b1;
			ED_OUT        <= `ED_CODE_LO;
		end else begin
			bg_shift_ff <= nxt_bg_shift;
			if (PIX_VALID_IN) begin
				if (LINE_START_IN)
					bg_cnt_ff <= {{(`BG_CNT_W-1){1'b0}}, bright_pix};
				else if (bright_pix && (bg_cnt_ff != {`BG_CNT_W{1'b1}}))
					bg_cnt_ff <= bg_cnt_ff + 1'b1;
				err_ff <= ed_corr - ed_emit;
			end
			if (PIX_VALID_IN && LINE_START_IN) begin
				thr_mean_ff <= `SLICE_MEDIAN;
				inside_ff   <= 1'b0;
			end else if (e_valid && e_edge) begin
				thr_mean_ff <= mean_sum[8:1];
				inside_ff   <= e_dark;
			end
			if (MODE_IN == `MODE_EDGE_TEXT) begin
				BIN_VALID_OUT <= e_valid;
				if (e_valid)
					BIN_OUT <= edge_bin;
			end else begin
				BIN_VALID_OUT <= PIX_VALID_IN;
				if (PIX_VALID_IN && (MODE_IN == `MODE_DIFFUSE)) begin
					BIN_OUT <= ed_white;
					ED_OUT  <= ed_white ? `ED_CODE_HI : `ED_CODE_LO;
				end else if (PIX_VALID_IN) begin
					BIN_OUT <= GRAY_IN >= slice_eff;
				end
			end
		end
	end

	// 3-D table: cell from upper bits of all three components
	scan_table_mem #(
		.DW (`LUT_DW),
		.AW (`LUT_AW)
	) u_lut (
		.clk_in    (REF_CLK_IN),
		.we_in     (LUT_WE_IN),
		.waddr_in  (LUT_ADDR_IN),
		.wdata_in  (LUT_DATA_IN),
		.raddr_in  ({RED_IN[`LUT_CELL_MSB:`LUT_CELL_LSB],
		             GREEN_IN[`LUT_CELL_MSB:`LUT_CELL_LSB],
		             BLUE_IN[`LUT_CELL_MSB:`LUT_CELL_LSB]}),
		.rdata_out (lut_rdata)
	);

	// Each entry holds base and slope per channel; fraction interpolates
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
			wire        [7:0]  base;
			wire signed [7:0]  slope;
			wire signed [13:0] prod;
			wire signed [10:0] sum;
			assign base  = lut_rdata[ch*`LUT_CH_W +: 8];
			assign slope = lut_rdata[ch*`LUT_CH_W + 8 +: 8];
			assign prod  = slope *
			               $signed({1'b0, col_rgb_ff[ch*8 +: `LUT_FRAC_W]});
			assign sum   = $signed({3'b000, base}) +
			               $signed(prod[13:`LUT_FRAC_W]);
			assign corr_rgb[ch*8 +: 8] = sum[10] ? 8'h00 :
			       (sum[9:8] != 2'b00) ? 8'hFF : sum[7:0];
		end
	endgenerate

	always @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			col_valid_ff    <= 1'b0;
			col_bypass_ff   <= 1'b1;
			col_drop_ff     <= 1'b0;
			col_rgb_ff      <= 24'h000000;
			COLOR_VALID_OUT <= 1'b0;
			RED_OUT         <= 8'h00;
			GREEN_OUT       <= 8'h00;
			BLUE_OUT        <= 8'h00;
			LAMP_ALL_ON_OUT <= 3'h7;
		end else begin
			LAMP_ALL_ON_OUT <= 3'h7;
			col_valid_ff    <= PIX_VALID_IN;
			if (PIX_VALID_IN) begin
				col_bypass_ff <= !COLOR_DATA_IN;
				col_drop_ff   <= DROPOUT_EN_IN && in_range;
				col_rgb_ff    <= rgb_in;
			end
			COLOR_VALID_OUT <= col_valid_ff;
			if (col_valid_ff && col_bypass_ff) begin
				{RED_OUT, GREEN_OUT, BLUE_OUT} <= col_rgb_ff;
			end else if (col_valid_ff && col_drop_ff) begin
				{RED_OUT, GREEN_OUT, BLUE_OUT} <= 24'hFFFFFF;
			end else if (col_valid_ff) begin
				{RED_OUT, GREEN_OUT, BLUE_OUT} <= corr_rgb;
			end
		end
	end

	// Stored line feeds the second, thinned binary output after the first
	assign line_we = PIX_VALID_IN && DUAL_EN_IN && (dual_st_ff == ST_IDLE);

	scan_table_mem #(
		.DW (8),
		.AW (`LINE_AW)
	) u_line (
		.clk_in    (REF_CLK_IN),
		.we_in     (line_we),
		.waddr_in  (LINE_START_IN ? {`LINE_AW{1'b0}} : wcnt_ff),
		.wdata_in  (GRAY_IN),
		.raddr_in  (raddr_ff[`LINE_AW-1:0]),
		.rdata_out (line_rdata)
	);

	always @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			dual_st_ff     <= ST_IDLE;
			wcnt_ff        <= {`LINE_AW{1'b0}};
			len_ff         <= {(`LINE_AW+1){1'b0}};
			raddr_ff       <= {(`LINE_AW+1){1'b0}};
			rd_pend_ff     <= 1'b0;
			DUAL_BUSY_OUT  <= 1'b0;
			DUAL_VALID_OUT <= 1'b0;
			DUAL_BIN_OUT   <= 1'b1;
		end else begin
			DUAL_VALID_OUT <= rd_pend_ff;
			if (rd_pend_ff)
				DUAL_BIN_OUT <= line_rdata >= SLICE_LEVEL_IN;
			case (dual_st_ff)
			ST_IDLE: begin
				rd_pend_ff <= 1'b0;
				if (line_we) begin
					wcnt_ff <= LINE_START_IN ? {{(`LINE_AW-1){1'b0}}, 1'b1} :
					           wcnt_ff + 1'b1;
				end
				if (line_we && LINE_END_IN) begin
					len_ff        <= LINE_START_IN ? 14'h0001 :
					                 {1'b0, wcnt_ff} + 1'b1;
					raddr_ff      <= {(`LINE_AW+1){1'b0}};
					dual_st_ff    <= ST_REPLAY;
					DUAL_BUSY_OUT <= 1'b1;
				end
			end
			ST_REPLAY: begin
				if (raddr_ff < len_ff) begin
					rd_pend_ff <= 1'b1;
					raddr_ff   <= raddr_ff + `DUAL_STEP;
				end else begin
					rd_pend_ff    <= 1'b0;
					dual_st_ff    <= ST_IDLE;
					DUAL_BUSY_OUT <= 1'b0;
					wcnt_ff       <= {`LINE_AW{1'b0}};
				end
			end
			default: dual_st_ff <= ST_IDLE;
			endcase
		end
	end
endmodule

// *** hw/scan_table_mem.v ***
// Simple dual-port memory with one write port and a registered read port.
// Assumes both ports run on the pixel clock; read data lag the address by
// one cycle.
`timescale 1ns/1ps
module scan_table_mem #(
	parameter DW = 8,
	parameter AW = 9
) (
	input  wire          clk_in,
	input  wire          we_in,
	input  wire [AW-1:0] waddr_in,
	input  wire [DW-1:0] wdata_in,
	input  wire [AW-1:0] raddr_in,
	output reg  [DW-1:0] rdata_out
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
		rdata_out <= mem[raddr_in];
	end
endmodule

// *** verification/scan_binarize_color_correct_sva.sv ***
// Port-level assertions for the pixel binarizing and colour stage.
// Assumes the single pixel clock and the synchronous active-high reset.
`timescale 1ns/1ps
`include "scan_proc_defs.vh"
module scan_binarize_color_correct_sva (
	input wire        REF_CLK_IN,
	input wire        RST_IN,
	input wire        PIX_VALID_IN,
	input wire        LINE_START_IN,
	input wire        LINE_END_IN,
	input wire [7:0]  GRAY_IN,
	input wire        COLOR_DATA_IN,
	input wire [7:0]  RED_IN,
	input wire [7:0]  GREEN_IN,
	input wire [7:0]  BLUE_IN,
	input wire [1:0]  MODE_IN,
	input wire [7:0]  SLICE_LEVEL_IN,
	input wire [7:0]  ED_BRIGHT_IN,
	input wire        BG_TRACK_EN_IN,
	input wire        DROPOUT_EN_IN,
	input wire [23:0] DROP_LO_IN,
	input wire [23:0] DROP_HI_IN,
	input wire        DUAL_EN_IN,
	input wire        BIN_VALID_OUT,
	input wire        BIN_OUT,
	input wire [3:0]  ED_OUT,
	input wire        COLOR_VALID_OUT,
	input wire [7:0]  RED_OUT,
	input wire [7:0]  GREEN_OUT,
	input wire [7:0]  BLUE_OUT,
	input wire [2:0]  LAMP_ALL_ON_OUT,
	input wire        DUAL_BUSY_OUT,
	input wire        DUAL_VALID_OUT
);
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (RST_IN);
	wire [23:0] rgb_i = {RED_IN, GREEN_IN, BLUE_IN};
	wire [23:0] rgb_o = {RED_OUT, GREEN_OUT, BLUE_OUT};
	wire in_rng = RED_IN >= DROP_LO_IN[23:16] && RED_IN <= DROP_HI_IN[23:16]
		&& GREEN_IN >= DROP_LO_IN[15:8] && GREEN_IN <= DROP_HI_IN[15:8]
		&& BLUE_IN >= DROP_LO_IN[7:0] && BLUE_IN <= DROP_HI_IN[7:0];
	wire diff_px = PIX_VALID_IN && MODE_IN == `MODE_DIFFUSE;
	sequence s_end_taken;
		PIX_VALID_IN && LINE_END_IN && DUAL_EN_IN && !DUAL_BUSY_OUT;
	endsequence
	a_lamps_lit: assert property (LAMP_ALL_ON_OUT == 3'h7)
		else $error("lamp not all on");
	a_slice_cut: assert property (PIX_VALID_IN && MODE_IN == `MODE_SIMPLE
		&& !BG_TRACK_EN_IN |=> BIN_VALID_OUT
		&& BIN_OUT == ($past(GRAY_IN) >= $past(SLICE_LEVEL_IN)))
		else $error("simple binarize wrong");
	a_diff_code: assert property (diff_px |=> BIN_VALID_OUT
		&& ED_OUT == (BIN_OUT ? `ED_CODE_HI : `ED_CODE_LO))
		else $error("diffusion code wrong");
	a_diff_fresh: assert property (diff_px && LINE_START_IN
		&& ED_BRIGHT_IN == 8'h00
		|=> BIN_OUT == ($past(GRAY_IN) >= `SLICE_MEDIAN))
		else $error("diffusion line start wrong");
	a_gray_pass: assert property (PIX_VALID_IN && !COLOR_DATA_IN
		&& !DROPOUT_EN_IN |-> ##2 COLOR_VALID_OUT && rgb_o == $past(rgb_i, 2))
		else $error("gray bypass wrong");
	a_drop_white: assert property (PIX_VALID_IN && COLOR_DATA_IN
		&& DROPOUT_EN_IN && in_rng |-> ##2 rgb_o == 24'hFFFFFF)
		else $error("dropout not white");
	a_color_src: assert property (COLOR_VALID_OUT |-> $past(PIX_VALID_IN, 2))
		else $error("colour result without pixel");
	a_dual_busy: assert property (s_end_taken |=> DUAL_BUSY_OUT)
		else $error("replay busy missing");
	a_dual_first: assert property (s_end_taken
		|-> ##2 !DUAL_VALID_OUT ##1 DUAL_VALID_OUT)
		else $error("replay first output late");
	a_dual_inside: assert property (DUAL_VALID_OUT |-> $past(DUAL_BUSY_OUT))
		else $error("replay output outside busy");
endmodule
bind scan_binarize_color_correct scan_binarize_color_correct_sva chk (
	.REF_CLK_IN, .RST_IN, .PIX_VALID_IN, .LINE_START_IN, .LINE_END_IN,
	.GRAY_IN, .COLOR_DATA_IN, .RED_IN, .GREEN_IN, .BLUE_IN, .MODE_IN,
	.SLICE_LEVEL_IN, .ED_BRIGHT_IN, .BG_TRACK_EN_IN, .DROPOUT_EN_IN,
	.DROP_LO_IN, .DROP_HI_IN, .DUAL_EN_IN, .BIN_VALID_OUT, .BIN_OUT, .ED_OUT,
	.COLOR_VALID_OUT, .RED_OUT, .GREEN_OUT, .BLUE_OUT, .LAMP_ALL_ON_OUT,
	.DUAL_BUSY_OUT, .DUAL_VALID_OUT
);

// *** verification/scan_binarize_color_correct_test.sv ***
// Self-checking bench for the pixel stage, acting as the upstream pipeline.
// Assumes the result sink as downstream memory and the bound checker.
`timescale 1ns/1ps
`include "scan_proc_defs.vh"
module scan_binarize_color_correct_test;
	reg         REF_CLK_IN = 1'b0, RST_IN = 1'b1, PIX_VALID_IN = 1'b0;
	reg         LINE_START_IN = 1'b0, LINE_END_IN = 1'b0, COLOR_DATA_IN = 1'b0;
	reg         BG_TRACK_EN_IN = 1'b0, DROPOUT_EN_IN = 1'b0, LUT_WE_IN = 1'b0;
	reg         DUAL_EN_IN = 1'b0;
	reg  [7:0]  GRAY_IN = 8'h00, RED_IN = 8'h00, GREEN_IN = 8'h00;
	reg  [7:0]  BLUE_IN = 8'h00, SLICE_LEVEL_IN = 8'h80, ED_BRIGHT_IN = 8'h00;
	reg  [7:0]  BG_BRIGHT_IN = 8'h80, EDGE_LEVEL_IN = 8'h50;
	reg  [1:0]  MODE_IN = `MODE_SIMPLE;
	reg  [12:0] BG_LIMIT_IN = 13'h0001;
	reg  [23:0] DROP_LO_IN = 24'h000000, DROP_HI_IN = 24'hFFFFFF;
	reg  [8:0]  LUT_ADDR_IN = 9'h000;
	reg  [47:0] LUT_DATA_IN = 48'h0;
	wire        BIN_VALID_OUT, BIN_OUT, COLOR_VALID_OUT, DUAL_BUSY_OUT;
	wire        DUAL_VALID_OUT, DUAL_BIN_OUT;
	wire [3:0]  ED_OUT;
	wire [7:0]  RED_OUT, GREEN_OUT, BLUE_OUT;
	wire [2:0]  LAMP_ALL_ON_OUT;
	integer     errors = 0, checks_done = 0, i;
	initial forever #20 REF_CLK_IN = ~REF_CLK_IN;
	scan_binarize_color_correct DUT (
		.REF_CLK_IN, .RST_IN, .PIX_VALID_IN, .LINE_START_IN, .LINE_END_IN,
		.GRAY_IN, .COLOR_DATA_IN, .RED_IN, .GREEN_IN, .BLUE_IN, .MODE_IN,
		.SLICE_LEVEL_IN, .ED_BRIGHT_IN, .BG_TRACK_EN_IN, .BG_BRIGHT_IN,
		.BG_LIMIT_IN, .EDGE_LEVEL_IN, .DROPOUT_EN_IN, .DROP_LO_IN, .DROP_HI_IN,
		.LUT_WE_IN, .LUT_ADDR_IN, .LUT_DATA_IN, .DUAL_EN_IN, .BIN_VALID_OUT,
		.BIN_OUT, .ED_OUT, .COLOR_VALID_OUT, .RED_OUT, .GREEN_OUT, .BLUE_OUT,
		.LAMP_ALL_ON_OUT, .DUAL_BUSY_OUT, .DUAL_VALID_OUT, .DUAL_BIN_OUT
	);
	scan_result_sink sink (
		.clk_in(REF_CLK_IN), .bin_valid_in(BIN_VALID_OUT), .bin_in(BIN_OUT),
		.ed_in(ED_OUT), .color_valid_in(COLOR_VALID_OUT),
		.rgb_in({RED_OUT, GREEN_OUT, BLUE_OUT}),
		.dual_valid_in(DUAL_VALID_OUT), .dual_bin_in(DUAL_BIN_OUT)
	);
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", checks_done, errors);
			if (errors == 0 && checks_done > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// Upstream holds off while a stored line replays
	task pix(input [7:0] g, input s, input e);
		integer k;
		begin
			for (k = 0; k < 60 && DUAL_BUSY_OUT !== 1'b0; k = k + 1) begin
				@(posedge REF_CLK_IN);
				#1;
			end
			if (k == 60) begin
				chk(1, 0);
				wrap_up;
			end
			@(posedge REF_CLK_IN);
			#1;
			PIX_VALID_IN = 1'b1;
			GRAY_IN = g;
			LINE_START_IN = s;
			LINE_END_IN = e;
		end
	endtask
	task idle(input integer n);
		begin
			repeat (n) begin
				@(posedge REF_CLK_IN);
				#1;
				PIX_VALID_IN = 1'b0;
				LINE_START_IN = 1'b0;
				LINE_END_IN = 1'b0;
			end
		end
	endtask
	// Bit k of v is the expected result of the k-th stored pixel
	task expb(input [7:0] v, input integer n);
		integer k;
		begin
			for (k = 0; k < n; k = k + 1)
				chk(sink.bq.pop_front(), v[k]);
		end
	endtask
	initial begin
		repeat (6) @(posedge REF_CLK_IN);
		#1;
		RST_IN = 1'b0;
		chk(LAMP_ALL_ON_OUT, 3'h7);
		pix(8'h80, 1, 0);
		pix(8'h7F, 0, 0);
		pix(8'h81, 0, 1);
		idle(3);
		SLICE_LEVEL_IN = 8'h40;
		pix(8'h50, 1, 1);
		idle(3);
		expb(8'b1101, 4);
		$display("simple slice test done");
		sink.eq.delete();
		MODE_IN = `MODE_DIFFUSE;
		SLICE_LEVEL_IN = 8'h10;
		pix(8'h60, 1, 0);
		pix(8'h30, 0, 1);
		pix(8'h90, 1, 1);
		idle(3);
		ED_BRIGHT_IN = 8'h20;
		pix(8'h70, 1, 1);
		idle(3);
		expb(8'b1110, 4);
		chk(sink.eq.pop_front(), `ED_CODE_LO);
		chk(sink.eq.pop_front(), `ED_CODE_HI);
		$display("diffusion test done");
		MODE_IN = `MODE_SIMPLE;
		ED_BRIGHT_IN = 8'h00;
		SLICE_LEVEL_IN = 8'h80;
		BG_TRACK_EN_IN = 1'b1;
		pix(8'hF0, 1, 0);
		pix(8'hF0, 0, 0);
		pix(8'hF0, 0, 1);
		pix(8'h7E, 1, 1);
		idle(3);
		BG_TRACK_EN_IN = 1'b0;
		expb(8'b1111, 4);
		$display("background tracking test done");
		// Window emits a white lead-in result at each line start
		MODE_IN = `MODE_EDGE_TEXT;
		pix(8'hB0, 1, 0);
		pix(8'hB0, 0, 0);
		pix(8'h20, 0, 0);
		pix(8'h20, 0, 0);
		pix(8'h20, 0, 0);
		pix(8'hB0, 0, 0);
		pix(8'hB0, 0, 1);
		idle(6);
		expb(8'b1000111, 7);
		$display("edge text test done");
		// Earlier gray pixels also left colour results behind
		sink.cq.delete();
		MODE_IN = `MODE_SIMPLE;
		LUT_WE_IN = 1'b1;
		LUT_ADDR_IN = 9'h053;
		LUT_DATA_IN = 48'h2010_4030_0050;
		idle(1);
		LUT_WE_IN = 1'b0;
		COLOR_DATA_IN = 1'b1;
		{RED_IN, GREEN_IN, BLUE_IN} = 24'h214263;
		pix(8'h00, 1, 1);
		idle(3);
		COLOR_DATA_IN = 1'b0;
		{RED_IN, GREEN_IN, BLUE_IN} = 24'h123456;
		pix(8'h00, 1, 1);
		idle(3);
		COLOR_DATA_IN = 1'b1;
		{RED_IN, GREEN_IN, BLUE_IN} = 24'h214263;
		DROPOUT_EN_IN = 1'b1;
		pix(8'h00, 1, 1);
		idle(3);
		DROP_HI_IN = 24'h101010;
		pix(8'h00, 1, 1);
		idle(3);
		DROPOUT_EN_IN = 1'b0;
		chk(sink.cq.pop_front(), 24'h113450);
		chk(sink.cq.pop_front(), 24'h123456);
		chk(sink.cq.pop_front(), 24'hFFFFFF);
		chk(sink.cq.pop_front(), 24'h113450);
		$display("colour correction test done");
		DUAL_EN_IN = 1'b1;
		for (i = 0; i < 8; i = i + 1)
			pix(i == 0 ? 8'h90 : (i == 6 ? 8'h10 : 8'hF0), i == 0, i == 7);
		idle(20);
		DUAL_EN_IN = 1'b0;
		chk(sink.dq.pop_front(), 1);
		chk(sink.dq.pop_front(), 0);
		chk(sink.dq.size(), 0);
		$display("dual output test done");
		wrap_up;
	end
endmodule

// *** verification/scan_result_sink.sv ***
// Downstream image memory model: stores every result the stage emits.
// Assumes results are qualified by one-cycle valid pulses.
`timescale 1ns/1ps
module scan_result_sink (
	input wire        clk_in,
	input wire        bin_valid_in,
	input wire        bin_in,
	input wire [3:0]  ed_in,
	input wire        color_valid_in,
	input wire [23:0] rgb_in,
	input wire        dual_valid_in,
	input wire        dual_bin_in
);
	logic        bq[$];
	logic [3:0]  eq[$];
	logic [23:0] cq[$];
	logic        dq[$];
	// Memory never stalls, so each pulse is one stored result
	always @(posedge clk_in) begin
		if (bin_valid_in === 1'b1) begin
			bq.push_back(bin_in);
			eq.push_back(ed_in);
		end
		if (color_valid_in === 1'b1)
			cq.push_back(rgb_in);
		if (dual_valid_in === 1'b1)
			dq.push_back(dual_bin_in);
	end
endmodule
